// File: core/tst_core.sv
// tdm stream timing, data memory and connection control with wishbone slave
//
// Behaviour
// RL1: input stream delayed zero to seven bits
// RL2: slow input sample point in quarter steps
// RL3: fast input samples half or end only
// RL4: first bit after boundary is msb
// RL5: output advanced zero to seven whole bits
// RL6: output fractional advance in quarter steps
// RL7: fast output fraction zero or half
// RL8: strobe shares its stream's advance
// RL9: strobe extra advance up to full bit
// RL10: avoid delay on bidirectional streams
// RL11: throughput mode chosen per channel
// RL12: host sets variable enable before use
// RL13: variable delay reads newest written frame
// RL14: constant delay two frames plus offset
// RL15: constant delay works with variable enabled
// RL16: connection words single access, zero pad
// RL17: law bit low ignores high word
// RL18: normal mode picks source stream, channel
// RL19: host writes high word before law
// RL20: special mode sends message byte
// RL21: unused channel drives strobe high
// RL22: frame boundary is fall with pulse low
// RL23: streams timed independently of each other
`timescale 1ns/1ps
module tst_core
   import tst_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // tdm link
   input wire logic link_clk_i,
   input wire logic frame_pulse_n_i,
   input wire logic [NS-1:0] serial_in_i,
   output logic [NO-1:0] serial_out_o,
   output logic [NO-1:0] serial_out_oe_o,
   output logic [NO-1:0] ext_hiz_strobe_o
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic ck_s1_q, ck_s2_q, ck_s3_q;
   logic fp_s1_q, fp_s2_q;
   logic bit_fall;
   logic [PH_W-1:0] phase_q, phase_d, period_q, period_d;
   logic [POS_W-1:0] bit_cnt_q, bit_cnt_d;
   logic [BANK_W-1:0] frame_q, frame_d;
   logic synced_q, synced_d;
   logic [15:0] chip_q, chip_d;
   logic [15:0] sicr_q [NS];
   logic [15:0] sicr_d [NS];
   logic [15:0] socr_q [NO];
   logic [15:0] socr_d [NO];
   logic [15:0] cml_q [CM_WORDS];
   logic [15:0] cml_d [CM_WORDS];
   logic [4:0] cmh_q [CM_WORDS];
   logic [4:0] cmh_d [CM_WORDS];
   logic [7:0] dmem_q [DM_WORDS];
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic bus_req, adr_ok;
   logic [11:0] adr;
   logic [NS-1:0] in_wr;
   logic [CH_W-1:0] in_ch [NS];
   logic [BANK_W-1:0] in_bank [NS];
   logic [7:0] in_byte [NS];
   logic [CH_W-1:0] data_ch [NO];
   logic [CH_W-1:0] hiz_ch [NO];
   logic [NO-1:0] data_wrap, data_off, hiz_off;
   logic [7:0] out_byte [NO];

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
      return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // link clock and frame pulse sampling
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ck_s1_q <= 1'b1;
         ck_s2_q <= 1'b1;
         ck_s3_q <= 1'b1;
         fp_s1_q <= 1'b1;
         fp_s2_q <= 1'b1;
      end else begin
         ck_s1_q <= link_clk_i;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         fp_s1_q <= frame_pulse_n_i;
         fp_s2_q <= fp_s1_q;
      end
   end

   assign bit_fall = ck_s3_q && !ck_s2_q;

   // ----------------------------------------------------------------
   // bit and frame counters
   // ----------------------------------------------------------------
   // bit period is measured, so fractions track link clock rates of up to 255 system clocks per bit
   always_comb begin
      phase_d = (phase_q == 8'hff) ? phase_q : phase_q + 8'h01;
      period_d = period_q;
      bit_cnt_d = bit_cnt_q;
      frame_d = frame_q;
      synced_d = synced_q;
      if (bit_fall) begin
         phase_d = 8'h00;
         period_d = phase_q + 8'h01;
         // RL22: boundary on fall, pulse low
         if (!fp_s2_q) begin
            bit_cnt_d = 8'h00;
            frame_d = frame_q + 2'h1;
            synced_d = 1'b1;
         end else begin
            bit_cnt_d = bit_cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         phase_q <= 8'h00;
         period_q <= PERIOD_RST;
         bit_cnt_q <= 8'h00;
         frame_q <= 2'h0;
         synced_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         period_q <= period_d;
         bit_cnt_q <= bit_cnt_d;
         frame_q <= frame_d;
         synced_q <= synced_d;
      end
   end

   // ----------------------------------------------------------------
   // register file and wishbone slave
   // ----------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign adr = wb_adr_i[11:0];
   assign adr_ok = (wb_adr_i[31:12] == 20'h0_0000) && (adr[1:0] == 2'h0);

   always_comb begin
      chip_d = chip_q;
      for (int i = 0; i < NS; i++) begin
         sicr_d[i] = sicr_q[i];
      end
      for (int i = 0; i < NO; i++) begin
         socr_d[i] = socr_q[i];
      end
      for (int i = 0; i < CM_WORDS; i++) begin
         cml_d[i] = cml_q[i];
         cmh_d[i] = cmh_q[i];
      end
      ack_d = bus_req;
      rdat_d = 32'h0000_0000;
      // unmapped addresses answer with zero and drop writes
      if (bus_req && adr_ok) begin
         if (adr == ADDR_CHIP) begin
            rdat_d[15:0] = chip_q;
            if (wb_we_i) begin
               chip_d = merge16(chip_q, wb_dat_i, wb_sel_i);
            end
         end else if (adr == ADDR_STATUS) begin
            rdat_d[ST_BIT_LSB +: POS_W] = bit_cnt_q;
            rdat_d[ST_FRAME_LSB +: BANK_W] = frame_q;
            rdat_d[ST_SYNC] = synced_q;
         end else if (adr[11:3] == ADDR_SICR_BASE[11:3]) begin
            rdat_d[15:0] = sicr_q[adr[2]];
            if (wb_we_i) begin
               sicr_d[adr[2]] = merge16(sicr_q[adr[2]], wb_dat_i, wb_sel_i);
            end
         end else if (adr[11:3] == ADDR_SOCR_BASE[11:3]) begin
            rdat_d[15:0] = socr_q[adr[2]];
            if (wb_we_i) begin
               socr_d[adr[2]] = merge16(socr_q[adr[2]], wb_dat_i, wb_sel_i);
            end
         end else if (adr[11:8] == ADDR_CML_BASE[11:8]) begin
            // RL16: whole word, one access
            rdat_d[15:0] = cml_q[adr[7:2]];
            if (wb_we_i) begin
               cml_d[adr[7:2]] = merge16(cml_q[adr[7:2]], wb_dat_i, wb_sel_i);
            end
         end else if (adr[11:8] == ADDR_CMH_BASE[11:8]) begin
            // RL16: five bits, rest zero
            rdat_d[4:0] = cmh_q[adr[7:2]];
            if (wb_we_i && wb_sel_i[0]) begin
               cmh_d[adr[7:2]] = wb_dat_i[4:0];
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         chip_q <= CHIP_RST;
         for (int i = 0; i < NS; i++) begin
            sicr_q[i] <= SICR_RST;
         end
         for (int i = 0; i < NO; i++) begin
            socr_q[i] <= SOCR_RST;
         end
         for (int i = 0; i < CM_WORDS; i++) begin
            cml_q[i] <= CML_RST;
            cmh_q[i] <= CMH_RST;
         end
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         chip_q <= chip_d;
         for (int i = 0; i < NS; i++) begin
            sicr_q[i] <= sicr_d[i];
         end
         for (int i = 0; i < NO; i++) begin
            socr_q[i] <= socr_d[i];
         end
         for (int i = 0; i < CM_WORDS; i++) begin
            cml_q[i] <= cml_d[i];
            cmh_q[i] <= cmh_d[i];
         end
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ----------------------------------------------------------------
   // input streams and data memory
   // ----------------------------------------------------------------
   for (genvar s = 0; s < NS; s++) begin : g_in
      tst_stream_in u_in (
         .clk_sys_i(clk_sys_i),
         .rst_i(rst_i),
         .bit_fall_i(bit_fall),
         .phase_i(phase_q),
         .period_i(period_q),
         .bit_cnt_i(bit_cnt_q),
         .frame_i(frame_q),
         .synced_i(synced_q),
         .ctrl_i(sicr_q[s]),
         .serial_in_i(serial_in_i[s]),
         .wr_o(in_wr[s]),
         .wr_ch_o(in_ch[s]),
         .wr_bank_o(in_bank[s]),
         .wr_byte_o(in_byte[s])
      );
   end

   // four frame banks per stream so constant delay never meets the writer
   always_ff @(posedge clk_sys_i) begin
      for (int s = 0; s < NS; s++) begin
         if (in_wr[s]) begin
            dmem_q[{1'(s), in_bank[s], in_ch[s]}] <= in_byte[s];
         end
      end
   end

   // ----------------------------------------------------------------
   // connection lookup per output stream
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] w;
      logic [15:0] wh;
      logic [4:0] h;
      logic [CH_W-1:0] m;
      logic [4:0] src;
      logic [BANK_W-1:0] obank;
      logic [BANK_W-1:0] bank;
      logic [7:0] b;
      w = 16'h0000;
      wh = 16'h0000;
      h = 5'h00;
      m = '0;
      src = 5'h00;
      obank = '0;
      bank = '0;
      b = 8'h00;
      for (int o = 0; o < NO; o++) begin
         w = cml_q[{1'(o), data_ch[o]}];
         h = cmh_q[{1'(o), data_ch[o]}];
         // RL18: source channel and stream
         m = w[CL_SCA_LSB +: CH_W];
         src = w[CL_SSA_LSB +: 5];
         obank = frame_q + {1'b0, data_wrap[o]};
         // RL14: two frames back
         bank = obank - CONST_FRAMES;
         data_off[o] = 1'b0;
         if (w[CL_SPECIAL]) begin
            // RL20: message byte out
            b = w[CL_MSG_LSB +: 8];
            data_off[o] = (w[CL_MODE_LSB +: 2] != MODE_MSG);
         end else begin
            // RL11: per channel throughput mode
            if (w[CL_VAR]) begin
               // RL13: same frame when far enough ahead
               if ({1'b0, data_ch[o]} > {1'b0, m} + VAR_GAP) begin
                  bank = obank;
               end else begin
                  bank = obank - 2'h1;
               end
            end
            // RL15: constant stays valid when enabled
            b = dmem_q[{src[0], bank, m}];
            // RL12: variable without enable is invalid
            if ((w[CL_VAR] && !chip_q[CC_VAR_EN]) || (src >= 5'(NS))) begin
               b = INVALID_BYTE;
            end
         end
         // RL17: high word only with law bit
         if (w[CL_LAW] && h[CH_VOICE] && (h[CH_INLAW] != h[CH_OUTLAW])) begin
            b = b ^ LAW_XOR;
         end
         out_byte[o] = b;
         wh = cml_q[{1'(o), hiz_ch[o]}];
         hiz_off[o] = wh[CL_SPECIAL] && (wh[CL_MODE_LSB +: 2] != MODE_MSG);
      end
   end

   // ----------------------------------------------------------------
   // output streams
   // ----------------------------------------------------------------
   for (genvar o = 0; o < NO; o++) begin : g_out
      tst_stream_out u_out (
         .clk_sys_i(clk_sys_i),
         .rst_i(rst_i),
         .phase_i(phase_q),
         .period_i(period_q),
         .bit_cnt_i(bit_cnt_q),
         .enable_i(chip_q[CC_OUT_EN] && synced_q),
         .ctrl_i(socr_q[o]),
         .byte_i(out_byte[o]),
         .data_off_i(data_off[o]),
         .hiz_off_i(hiz_off[o]),
         .data_ch_o(data_ch[o]),
         .data_wrap_o(data_wrap[o]),
         .hiz_ch_o(hiz_ch[o]),
         .serial_out_o(serial_out_o[o]),
         .serial_out_oe_o(serial_out_oe_o[o]),
         .ext_hiz_strobe_o(ext_hiz_strobe_o[o])
      );
   end
endmodule // tst_core

// File: core/tst_stream_in.sv
// input stream bit delay, sampling point and byte assembly
`timescale 1ns/1ps
module tst_stream_in
   import tst_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // shared frame timing
   input wire logic bit_fall_i,
   input wire logic [PH_W-1:0] phase_i,
   input wire logic [PH_W-1:0] period_i,
   input wire logic [POS_W-1:0] bit_cnt_i,
   input wire logic [BANK_W-1:0] frame_i,
   input wire logic synced_i,
   // control and pin
   input wire logic [15:0] ctrl_i,
   input wire logic serial_in_i,
   // byte write to data memory
   output logic wr_o,
   output logic [CH_W-1:0] wr_ch_o,
   output logic [BANK_W-1:0] wr_bank_o,
   output logic [7:0] wr_byte_o
);
   logic din_s1_q, din_s2_q;
   logic [7:0] shift_q, shift_d;
   logic wr_q, wr_d;
   logic [CH_W-1:0] ch_q, ch_d;
   logic [BANK_W-1:0] bank_q, bank_d;
   logic [7:0] byte_q, byte_d;
   logic [2:0] delay;
   logic [1:0] smp;
   logic [2:0] k;
   logic [PH_W-1:0] quarter, sample_at;
   logic [POS_W-1:0] pos;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always_comb begin
      delay = ctrl_i[SI_DELAY_LSB +: 3];
      smp = ctrl_i[SI_SMP_LSB +: 2];
      quarter = period_i >> 2;
      // RL3: fast stream half steps
      if (ctrl_i[SI_RATE]) begin
         k = smp[0] ? 3'd4 : 3'd2;
      end else begin
         // RL2: quarter step sampling
         k = {1'b0, smp} + 3'd1;
      end
      case (k)
         3'd1: sample_at = quarter - 8'h01;
         3'd2: sample_at = {quarter[PH_W-2:0], 1'b0} - 8'h01;
         3'd3: sample_at = PH_W'(quarter + {quarter[PH_W-2:0], 1'b0} - 8'h01);
         // the fall phase already shows the next bit, so end of bit is one earlier
         default: sample_at = period_i - 8'h02;
      endcase
      // RL1: whole bit delay
      pos = bit_cnt_i - {5'h00, delay};
      shift_d = shift_q;
      wr_d = 1'b0;
      ch_d = ch_q;
      bank_d = bank_q;
      byte_d = byte_q;
      if (synced_i && !bit_fall_i && phase_i == sample_at) begin
         // RL4: first bit is msb
         shift_d = {shift_q[6:0], din_s2_q};
         if (pos[2:0] == 3'h7) begin
            wr_d = 1'b1;
            ch_d = pos[POS_W-1:3];
            bank_d = (bit_cnt_i < {5'h00, delay}) ? frame_i - 2'h1 : frame_i;
            byte_d = {shift_q[6:0], din_s2_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         din_s1_q <= 1'b0;
         din_s2_q <= 1'b0;
         shift_q <= 8'h00;
         wr_q <= 1'b0;
         ch_q <= '0;
         bank_q <= '0;
         byte_q <= 8'h00;
      end else begin
         din_s1_q <= serial_in_i;
         din_s2_q <= din_s1_q;
         shift_q <= shift_d;
         wr_q <= wr_d;
         ch_q <= ch_d;
         bank_q <= bank_d;
         byte_q <= byte_d;
      end
   end

   assign wr_o = wr_q;
   assign wr_ch_o = ch_q;
   assign wr_bank_o = bank_q;
   assign wr_byte_o = byte_q;
endmodule // tst_stream_in

// File: core/tst_stream_out.sv
// output stream advancement and high impedance strobe timing
`timescale 1ns/1ps
module tst_stream_out
   import tst_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // shared frame timing
   input wire logic [PH_W-1:0] phase_i,
   input wire logic [PH_W-1:0] period_i,
   input wire logic [POS_W-1:0] bit_cnt_i,
   input wire logic enable_i,
   // control and channel lookup
   input wire logic [15:0] ctrl_i,
   input wire logic [7:0] byte_i,
   input wire logic data_off_i,
   input wire logic hiz_off_i,
   output logic [CH_W-1:0] data_ch_o,
   output logic data_wrap_o,
   output logic [CH_W-1:0] hiz_ch_o,
   // pins
   output logic serial_out_o,
   output logic serial_out_oe_o,
   output logic ext_hiz_strobe_o
);
   logic out_q, out_d;
   logic oe_q, oe_d;
   logic hiz_q, hiz_d;
   logic [2:0] adv, hx, hq, tot;
   logic [1:0] frac;
   logic [POS_W:0] dpos, hpos;

   // early step when the phase has reached the fractional threshold
   function automatic logic carry(input logic [1:0] part, input logic [PH_W-1:0] ph,
                                  input logic [PH_W-1:0] per);
      logic [PH_W-1:0] q;
      logic [PH_W-1:0] thr;
      q = per >> 2;
      case (part)
         2'd1: thr = q;
         2'd2: thr = {q[PH_W-2:0], 1'b0};
         2'd3: thr = PH_W'(q + {q[PH_W-2:0], 1'b0});
         default: thr = '0;
      endcase
      return (part != 2'd0) && (ph >= per - thr);
   endfunction

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always_comb begin
      // RL5: whole bit advance
      adv = ctrl_i[SO_ADV_LSB +: 3];
      // RL6: quarter bit advance
      frac = ctrl_i[SO_FRAC_LSB +: 2];
      hx = ctrl_i[SO_HIZ_LSB +: 3];
      hq = (hx > HIZ_MAX_Q) ? HIZ_MAX_Q : hx;
      if (ctrl_i[SO_RATE]) begin
         // RL7: fast stream half only
         frac = {frac[1], 1'b0};
         // RL9: fast strobe steps
         hq = (hq == HIZ_MAX_Q) ? HIZ_MAX_Q : {1'b0, hq[1], 1'b0};
      end
      // RL8: strobe follows stream timing
      tot = {1'b0, frac} + hq;
      // RL23: per stream fields only
      dpos = {1'b0, bit_cnt_i} + {6'h00, adv} + {8'h00, carry(frac, phase_i, period_i)};
      hpos = {1'b0, bit_cnt_i} + {6'h00, adv} + {8'h00, tot[2]}
             + {8'h00, carry(tot[1:0], phase_i, period_i)};
      data_ch_o = dpos[POS_W-1:3];
      data_wrap_o = dpos[POS_W];
      hiz_ch_o = hpos[POS_W-1:3];
      out_d = byte_i[~dpos[2:0]];
      oe_d = enable_i && !data_off_i;
      // RL21: unused channel strobe high
      hiz_d = !enable_i || hiz_off_i;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
         oe_q <= 1'b0;
         hiz_q <= 1'b1;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
         hiz_q <= hiz_d;
      end
   end

   assign serial_out_o = out_q;
   assign serial_out_oe_o = oe_q;
   assign ext_hiz_strobe_o = hiz_q;
endmodule // tst_stream_out

// File: shared/tst_pkg.sv
// shared constants for the tdm stream timing and connection block
package tst_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NS = 2;
   localparam int NO = 2;
   localparam int CH = 32;
   localparam int CH_W = 5;
   localparam int BANK_W = 2;
   localparam int CM_WORDS = NO * CH;
   localparam int CM_IDX_W = 6;
   localparam int DM_WORDS = NS * CH * 4;
   localparam int DM_IDX_W = 8;
   localparam int PH_W = 8;
   localparam int POS_W = 8;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CHIP = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_SICR_BASE = 12'h040;
   localparam logic [11:0] ADDR_SOCR_BASE = 12'h080;
   localparam logic [11:0] ADDR_CML_BASE = 12'h400;
   localparam logic [11:0] ADDR_CMH_BASE = 12'h800;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CC_OUT_EN = 0;
   localparam int CC_VAR_EN = 4;
   localparam int ST_BIT_LSB = 0;
   localparam int ST_FRAME_LSB = 8;
   localparam int ST_SYNC = 15;
   localparam int SI_RATE = 0;
   localparam int SI_SMP_LSB = 4;
   localparam int SI_DELAY_LSB = 6;
   localparam int SO_RATE = 0;
   localparam int SO_ADV_LSB = 4;
   localparam int SO_FRAC_LSB = 7;
   localparam int SO_HIZ_LSB = 9;
   localparam int CL_SPECIAL = 0;
   localparam int CL_MODE_LSB = 1;
   localparam int CL_SCA_LSB = 1;
   localparam int CL_MSG_LSB = 3;
   localparam int CL_SSA_LSB = 9;
   localparam int CL_VAR = 14;
   localparam int CL_LAW = 15;
   localparam int CH_OUTLAW = 0;
   localparam int CH_INLAW = 1;
   localparam int CH_VOICE = 2;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [15:0] CHIP_RST = 16'h0000;
   localparam logic [15:0] SICR_RST = 16'h0020;
   localparam logic [15:0] SOCR_RST = 16'h0000;
   localparam logic [15:0] CML_RST = 16'h0001;
   localparam logic [4:0] CMH_RST = 5'h00;
   localparam logic [PH_W-1:0] PERIOD_RST = 8'h08;
   localparam logic [1:0] MODE_MSG = 2'h1;
   localparam logic [7:0] INVALID_BYTE = 8'hff;
   localparam logic [7:0] LAW_XOR = 8'h55;
   localparam logic [5:0] VAR_GAP = 6'h07;
   localparam logic [1:0] CONST_FRAMES = 2'h2;
   localparam logic [2:0] HIZ_MAX_Q = 3'h4;
endpackage

// File: verif/tst_core_asserts.sv
// checker on the core ports
`timescale 1ns/1ps
module tst_core_asserts
   import tst_pkg::*;
(
   // clock and bus
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // link outputs
   input wire logic [NO-1:0] serial_out_oe_o,
   input wire logic [NO-1:0] ext_hiz_strobe_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i, 1))
      else $error("ack without request");
   a_pad_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper bits set");
   a_high_pad: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:10] == 2'h2
      |-> wb_dat_o[15:5] == 11'h000) else $error("high word pad");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:0] == 12'h00c
      |-> wb_dat_o == 32'h0000_0000) else $error("unmapped data");
   a_oe_reset: assert property ($fell(rst_i) |-> serial_out_oe_o == '0)
      else $error("driving out of reset");
   a_hiz_reset: assert property ($fell(rst_i) |-> ext_hiz_strobe_o == '1)
      else $error("strobe low out of reset");
   c_write: cover property (wb_ack_o && wb_we_i);
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_drive: cover property (serial_out_oe_o[0]);
endmodule // tst_core_asserts
bind tst_core tst_core_asserts u_chk (.clk_sys_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .serial_out_oe_o, .ext_hiz_strobe_o);

// File: verif/tst_core_tb.sv
// self-checking bench for the tdm core
`timescale 1ns/1ps
module tst_core_tb
   import tst_pkg::*;
;
   logic clk_sys_i, rst_i, cyc, stb, we, ack, lclk, fp_n;
   logic [31:0] adr, wdat, rdat, q;
   logic [NS-1:0] sin;
   logic [NO-1:0] sout, soe, shz;
   logic [7:0] pos, b;
   logic [1:0] hz;
   int err_count, comparisons;
   tst_link_model lm (.link_clk_o(lclk), .frame_pulse_n_o(fp_n), .serial_in_o(sin),
      .bit_pos_o(pos));
   tst_core uut (.clk_sys_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .link_clk_i(lclk), .frame_pulse_n_i(fp_n), .serial_in_i(sin), .serial_out_o(sout),
      .serial_out_oe_o(soe), .ext_hiz_strobe_o(shz));
   // ----
   // tasks
   // ----
   task automatic summarize;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= 32'(a);
      wdat <= 32'(d);
      do @(posedge clk_sys_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // collects output 0 channel ch, sampled just before each bit ends
   task automatic grab(input int ch);
      do @(negedge lclk); while (pos != 8'(ch * 8));
      for (int i = 0; i < 8; i++) begin
         if (i > 0) @(negedge lclk);
         b = {b[6:0], sout[0]};
      end
      hz = {soe[0], shz[0]};
   endtask
   // ----
   // clock, watchdog, tests
   // ----
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #600_000;
      err_count++;
      summarize;
   end
   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = '0;
      wdat = '0;
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      wb(1'b0, 12'h040, 16'h0000);
      chk(q[15:0], 16'h0020);
      wb(1'b0, 12'h400, 16'h0000);
      chk(q[15:0], 16'h0001);
      wb(1'b0, 12'h00c, 16'h0000);
      chk(q[15:0], 16'h0000);
      wb(1'b1, 12'h81c, 16'hffff);
      wb(1'b0, 12'h81c, 16'h0000);
      chk(q[15:0], 16'h001f);
      wb(1'b1, 12'h82c, 16'h0006);
      wb(1'b1, 12'h414, 16'h052b);
      wb(1'b1, 12'h41c, 16'h0206);
      wb(1'b1, 12'h424, 16'h4206);
      wb(1'b1, 12'h42c, 16'h8206);
      wb(1'b1, 12'h000, 16'h0001);
      repeat (3) @(negedge fp_n);
      grab(5);
      chk({8'h00, b}, 16'h00a5);
      grab(7);
      chk({8'h00, b}, 16'h0083);
      chk({14'h0000, hz}, 16'h0002);
      grab(9);
      chk({8'h00, b}, 16'h00ff);
      grab(11);
      chk({8'h00, b}, 16'h00d6);
      grab(12);
      chk({14'h0000, hz}, 16'h0001);
      wb(1'b1, 12'h000, 16'h0011);
      wb(1'b1, 12'h044, 16'h0060);
      repeat (4) @(negedge fp_n);
      grab(7);
      chk({8'h00, b}, 16'h0007);
      grab(9);
      chk({8'h00, b}, 16'h0007);
      wb(1'b1, 12'h080, 16'h0010);
      @(negedge fp_n);
      grab(7);
      chk({8'h00, b}, 16'h000e);
      summarize;
   end
endmodule // tst_core_tb

// File: verif/tst_link_model.sv
// link partner: bit clock, frame pulse, input streams
`timescale 1ns/1ps
module tst_link_model
   import tst_pkg::*;
(
   // link pins and bit position
   output logic link_clk_o,
   output logic frame_pulse_n_o,
   output logic [NS-1:0] serial_in_o,
   output logic [7:0] bit_pos_o
);
   // byte of stream s channel c is {s, 00, c}
   function automatic logic pat(input int s, input logic [7:0] p);
      logic [7:0] b;
      b = {s[0], 2'b00, p[7:3]};
      return b[3'd7 - p[2:0]];
   endfunction
   initial begin
      link_clk_o = 1'b1;
      frame_pulse_n_o = 1'b1;
      bit_pos_o = 8'hff;
      serial_in_o = '0;
      forever #80 link_clk_o = ~link_clk_o;
   end
   // pulse low across the boundary fall only
   always @(posedge link_clk_o) frame_pulse_n_o <= (bit_pos_o != 8'hff);
   always @(negedge link_clk_o) begin
      bit_pos_o <= bit_pos_o + 8'h01;
      for (int s = 0; s < NS; s++) serial_in_o[s] <= pat(s, bit_pos_o + 8'h01);
   end
endmodule // tst_link_model
